// ===== hw/tsmj_pkg.sv
package tsmj_pkg;

	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int          CLK_MHZ      = 25;
	localparam int          SF_BASE_NS   = 526000;
	localparam int          MC_BASE_NS   = 256000;
	localparam int          SF_BASE_SPAN = 32;
	localparam int          MC_BASE_SPAN = 16;
	localparam int          SF_UNIT_CYC  = SF_BASE_NS * CLK_MHZ / 1000 / SF_BASE_SPAN;
	localparam int          MC_UNIT_CYC  = MC_BASE_NS * CLK_MHZ / 1000 / MC_BASE_SPAN;
	localparam logic [9:0]  SF_UNIT      = 10'(SF_UNIT_CYC);
	localparam logic [9:0]  MC_UNIT      = 10'(MC_UNIT_CYC);
	localparam logic [4:0]  CAL_SPAN     = 5'h10;
	localparam logic [7:0]  TEMP_PERIOD  = 8'h40;

	// ************************************************
	// Scale and targets
	// ************************************************
	localparam logic [15:0] SF_FULL      = 16'hA000;
	localparam logic [15:0] MC_FULL      = 16'h7800;
	localparam logic [9:0]  PM_SELF      = 10'h177;
	localparam logic [9:0]  PM_SHIELD    = 10'h096;
	localparam logic [9:0]  PM_MUTUAL    = 10'h0FA;
	localparam logic [9:0]  PM_DEN       = 10'h3E8;
	localparam logic [15:0] CAL_EXPECT   = 16'h1800;
	localparam logic [15:0] OFS_TOL      = 16'h0040;
	localparam logic [12:0] RECIP_ONE    = 13'h1000;
	localparam int          RECIP_SHIFT  = 12;

	// ************************************************
	// Spread controls
	// ************************************************
	localparam logic        PHASE_SHIFT_OFF = 1'b0;
	localparam logic        SPREAD_MODE     = 1'b0;
	localparam logic [3:0]  SPREAD_COUNT    = 4'h3;

	// ************************************************
	// Register map and reset values
	// ************************************************
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_TIMING  = 8'h04;
	localparam logic [7:0]  OFS_DPDIV   = 8'h08;
	localparam logic [7:0]  OFS_OFFSET  = 8'h0C;
	localparam logic [7:0]  OFS_THRESH  = 8'h10;
	localparam logic [7:0]  OFS_STATUS  = 8'h14;
	localparam logic [7:0]  OFS_RESULT  = 8'h18;
	localparam logic [7:0]  OFS_COEF    = 8'h1C;
	localparam logic [7:0]  OFS_SPREAD  = 8'h20;
	localparam logic [7:0]  OFS_TARGET  = 8'h24;
	localparam int          START_BIT   = 8;
	localparam logic [7:0]  CTRL_RST    = 8'h04;
	localparam logic [31:0] TIMING_RST  = 32'h0321_0F03;
	localparam logic [15:0] DPDIV_RST   = 16'h7777;
	localparam logic [9:0]  OFFSET_RST  = 10'h000;
	localparam logic [15:0] THRESH_RST  = 16'h2000;

	// ************************************************
	// Types
	// ************************************************
	typedef enum logic [1:0] {
		MT_SELF   = 2'b00,
		MT_SHIELD = 2'b01,
		MT_MUTUAL = 2'b10,
		MT_CURR   = 2'b11
	} tsmj_mtype_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CAL   = 3'b001,
		ST_MEAS  = 3'b010,
		ST_JUDGE = 3'b011,
		ST_DONE  = 3'b100
	} tsmj_state_t;

	typedef struct packed {
		logic        multi;
		logic        vote_mode;
		logic        ofs_adj_en;
		logic        shield_en;
		logic        temp_en;
		logic        button_if;
		tsmj_mtype_t mtype;
	} tsmj_ctrl_t;

	typedef struct packed {
		logic       pad;
		logic [2:0] avg_log;
		logic [3:0] mult2;
		logic [3:0] mult1;
		logic [3:0] mult0;
		logic [3:0] state_clock_div;
		logic [3:0] config_pulse_divider;
		logic [1:0] pin_sel;
		logic [1:0] count_source_select;
		logic [3:0] meas_count_setting;
	} tsmj_timing_t;

endpackage

// ===== hw/tsmj_judge.sv
`timescale 1ns/1ps
module tsmj_judge
	import tsmj_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        load,
	input  wire logic        multi,
	input  wire logic        vote,
	input  wire logic [17:0] v1,
	input  wire logic [17:0] v2,
	input  wire logic [17:0] v3,
	input  wire logic [15:0] thr,
	output logic      [18:0] value_q,
	output logic             touch_q
);

	function automatic logic [17:0] absd(input logic [17:0] a, input logic [17:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	logic [18:0] d12;
	logic [18:0] d13w;
	logic [18:0] d23w;
	logic [18:0] sum;
	logic [2:0]  hit;
	logic        vtouch;

	// ************************************************
	// Pair choice and votes
	// ************************************************
	always_comb begin
		d12  = {1'b0, absd(v1, v2)};
		d13w = {absd(v1, v3), 1'b0};
		d23w = {1'b0, absd(v2, v3)} + {1'b0, absd(v2, v3) >> 1};
		if ((d12 <= d13w) && (d12 <= d23w)) begin
			sum = {1'b0, v1} + {1'b0, v2};
		end else if (d13w <= d23w) begin
			sum = {1'b0, v1} + {1'b0, v3};
		end else begin
			sum = {1'b0, v2} + {1'b0, v3};
		end
		hit[0] = v1 > {2'b00, thr};
		hit[1] = v2 > {2'b00, thr};
		hit[2] = v3 > {2'b00, thr};
		vtouch = (hit[0] & hit[1]) | (hit[0] & hit[2]) | (hit[1] & hit[2]);
	end

	// ************************************************
	// Result registers
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_q <= 19'h00000;
			touch_q <= 1'b0;
		end else if (load) begin
			if (!multi) begin
				value_q <= {1'b0, v1};
				touch_q <= hit[0];
			end else if (vote) begin
				value_q <= sum;
				touch_q <= vtouch;
			end else begin
				value_q <= sum;
				touch_q <= sum > {2'b00, thr, 1'b0};
			end
		end
	end

endmodule

// ===== hw/tsmj_top.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Offset tuning aims at 37.5% self, 15% shielded self, 25% mutual of full scale.
// - Single-frequency full scale is 40960 counts at 526us base time.
// - Multi-clock full scale is 30720 counts at 256us base time.
// - Target scales by actual measurement time over base time.
// - Offset starts at initial setting, refines per measurement, can be disabled.
// - Single-frequency spread controls fixed: phase shift 0, mode 0, count 3.
// - Base clock is input clock over count source and per-pin drive divider.
// - Count setting 3 with divider 7 gives 526us; time tracks both spans.
// - Multi-clock time per frequency: 3 gives 64us, 7 128us, F 256us.
// - Multi-clock measures at three frequencies and forms one result.
// - Drive frequency n is clock over dividers times multiplier n over pulse divider.
// - Vote mode judges each of three values, majority gives touch.
// - Vote mode only for self and mutual buttons; others use pairing.
// - Pair mode corrects to frequency one, sums the closest pair.
// - Pair mode weights difference one-three by 2 and two-three by 1.5.
// - Majority mode setting 1 selects vote mode, 0 selects pair mode.
// - Abnormal measurement sets flags; they clear once read.
// - Results pass a moving average over configurable sample count.
// - Shield pulse follows drive pulse, only for shielded self measurement.
// - Power-on calibration yields coefficient applied to every later measurement.
// - Temperature correction periodically refreshes coefficient via external resistor, only in multi-clock mode.
module tsmj_top
	import tsmj_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        cco_in,
	input  wire logic        overcurrent_in,
	input  wire logic        ref_cmp0_in,
	input  wire logic        ref_cmp1_in,
	output logic             drive_pulse,
	output logic             shield_pulse,
	output logic      [9:0]  offset_current,
	output logic             cal_active,
	output logic             temp_ref_sel,
	output logic             touch,
	output logic             done
);

	function automatic logic [12:0] recip(input logic [3:0] m);
		return (m == 4'h0) ? RECIP_ONE : 13'(RECIP_ONE / {9'h000, m});
	endfunction

	tsmj_ctrl_t   ctrl_q;
	tsmj_timing_t tim_q;
	tsmj_state_t  st_q;
	logic [15:0]  dpdiv_q;
	logic [15:0]  thr_q;
	logic [9:0]   ofs_q;
	logic [8:0]   stat_q;
	logic [31:0]  hrdata_q;
	logic [7:0]   a_addr_q;
	logic         a_wr_q;
	logic         start_q;
	logic [31:0]  rmux;
	logic         acc_rd;
	logic         acc_wr;
	logic [3:0]   s1_q;
	logic [3:0]   s2_q;
	logic         cco_d_q;
	logic         cco_edge;
	logic [3:0]   dpd;
	logic [7:0]   lim;
	logic [3:0]   mult;
	logic [8:0]   acc_q;
	logic [8:0]   acc_n;
	logic         drv_q;
	logic         run;
	logic [17:0]  win_len;
	logic [17:0]  win_q;
	logic         win_end;
	logic [15:0]  cnt_q;
	logic [1:0]   fi_q;
	logic [15:0]  coef_q;
	logic         coef_ok_q;
	logic [7:0]   tctr_q;
	logic         meas_next_q;
	logic [17:0]  vs_q [3];
	logic [17:0]  corr;
	logic [33:0]  fprod;
	logic         vote_ok;
	logic [18:0]  jval;
	logic         jtouch;
	logic [18:0]  hist_q [8];
	logic [2:0]   wr_q;
	logic [21:0]  sum_q;
	logic [21:0]  sum_n;
	logic [18:0]  avg_q;
	logic         touch_q;
	logic [15:0]  full;
	logic [9:0]   pm;
	logic [7:0]   span;
	logic [7:0]   bspan;
	logic [47:0]  tprod;
	logic [23:0]  target;

	// ************************************************
	// Bus slave
	// ************************************************
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign acc_rd    = hsel && hready && htrans[1] && !hwrite;
	assign acc_wr    = a_wr_q;

	always_comb begin
		rmux = 32'h0000_0000;
		case (haddr[7:0])
			OFS_CTRL:   rmux = {24'h000000, ctrl_q};
			OFS_TIMING: rmux = tim_q;
			OFS_DPDIV:  rmux = {16'h0000, dpdiv_q};
			OFS_OFFSET: rmux = {22'h000000, ofs_q};
			OFS_THRESH: rmux = {16'h0000, thr_q};
			OFS_STATUS: rmux = {20'h00000, coef_ok_q, (st_q != ST_IDLE), touch_q, stat_q};
			OFS_RESULT: rmux = {13'h0000, avg_q};
			OFS_COEF:   rmux = {16'h0000, coef_q};
			OFS_SPREAD: rmux = {26'h0000000, SPREAD_COUNT, SPREAD_MODE, PHASE_SHIFT_OFF};
			OFS_TARGET: rmux = {8'h00, target};
			default:    rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_addr_q <= 8'h00;
			a_wr_q   <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			a_wr_q <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1]) begin
				a_addr_q <= haddr[7:0];
			end
			if (acc_rd) begin
				hrdata_q <= rmux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= tsmj_ctrl_t'(CTRL_RST);
			tim_q   <= tsmj_timing_t'(TIMING_RST);
			dpdiv_q <= DPDIV_RST;
			thr_q   <= THRESH_RST;
			start_q <= 1'b0;
		end else begin
			start_q <= acc_wr && (a_addr_q == OFS_CTRL) && hwdata[START_BIT];
			if (acc_wr) begin
				case (a_addr_q)
					OFS_CTRL:   ctrl_q  <= tsmj_ctrl_t'(hwdata[7:0]);
					OFS_TIMING: tim_q   <= tsmj_timing_t'(hwdata);
					OFS_DPDIV:  dpdiv_q <= hwdata[15:0];
					OFS_THRESH: thr_q   <= hwdata[15:0];
					default:    ;
				endcase
			end
		end
	end

	// ************************************************
	// Pin synchronisers
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q    <= 4'h0;
			s2_q    <= 4'h0;
			cco_d_q <= 1'b0;
		end else begin
			s1_q    <= {ref_cmp1_in, ref_cmp0_in, overcurrent_in, cco_in};
			s2_q    <= s1_q;
			cco_d_q <= s2_q[0];
		end
	end

	assign cco_edge = s2_q[0] && !cco_d_q;

	// ************************************************
	// Drive pulse generation
	// ************************************************
	always_comb begin
		dpd = dpdiv_q[{tim_q.pin_sel, 2'b00} +: 4];
		if (ctrl_q.multi) begin
			lim = 8'({4'h0, tim_q.state_clock_div} + 8'h01) * 8'({4'h0, tim_q.config_pulse_divider} + 8'h01);
			case (fi_q)
				2'd1:    mult = tim_q.mult1;
				2'd2:    mult = tim_q.mult2;
				default: mult = tim_q.mult0;
			endcase
		end else begin
			lim  = 8'(8'h01 << tim_q.count_source_select) * 8'({4'h0, dpd} + 8'h01);
			mult = 4'h1;
		end
		acc_n = acc_q + {5'h00, mult};
		if (acc_n >= {1'b0, lim}) begin
			acc_n = acc_n - {1'b0, lim};
		end
	end

	assign run = (st_q == ST_MEAS) || (st_q == ST_CAL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= 9'h000;
			drv_q <= 1'b0;
		end else if (!run) begin
			acc_q <= 9'h000;
			drv_q <= 1'b0;
		end else begin
			acc_q <= acc_n;
			if ((acc_q + {5'h00, mult}) >= {1'b0, lim}) begin
				drv_q <= !drv_q;
			end
		end
	end

	assign drive_pulse  = drv_q;
	assign shield_pulse = drv_q && ctrl_q.multi && ctrl_q.shield_en
		&& (ctrl_q.mtype == MT_SHIELD) && (st_q == ST_MEAS);

	// ************************************************
	// Measurement window and counter
	// ************************************************
	always_comb begin
		if (st_q == ST_CAL) begin
			win_len = 18'({13'h0000, CAL_SPAN} * {8'h00, MC_UNIT});
		end else if (ctrl_q.multi) begin
			win_len = 18'({14'h0000, tim_q.meas_count_setting} * {8'h00, MC_UNIT} + {8'h00, MC_UNIT});
		end else begin
			win_len = 18'(({14'h0000, tim_q.meas_count_setting} + 18'h1)
				* ({14'h0000, dpd} + 18'h1) * {8'h00, SF_UNIT});
		end
	end

	assign win_end = run && (win_q == win_len - 18'h1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_q <= 18'h00000;
			cnt_q <= 16'h0000;
		end else if (!run || win_end) begin
			win_q <= 18'h00000;
			cnt_q <= 16'h0000;
		end else begin
			win_q <= win_q + 18'h1;
			if (cco_edge && (cnt_q != 16'hFFFF)) begin
				cnt_q <= cnt_q + 16'h1;
			end
		end
	end

	// ************************************************
	// Correction and frequency normalisation
	// ************************************************
	always_comb begin
		corr = 18'({2'b00, cnt_q} + {{2{coef_q[15]}}, coef_q});
		if (corr[17]) begin
			corr = 18'h00000;
		end
		fprod = 34'({16'h0000, corr} * {30'h0, tim_q.mult0} * {21'h0, recip(mult)});
	end

	// ************************************************
	// Sequencer
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q        <= ST_CAL;
			fi_q        <= 2'd0;
			coef_q      <= 16'h0000;
			coef_ok_q   <= 1'b0;
			tctr_q      <= 8'h00;
			meas_next_q <= 1'b0;
			vs_q        <= '{default: 18'h00000};
		end else begin
			case (st_q)
				ST_IDLE: begin
					fi_q <= 2'd0;
					if (start_q) begin
						if (ctrl_q.multi && ctrl_q.temp_en && (tctr_q == 8'h00)) begin
							st_q        <= ST_CAL;
							meas_next_q <= 1'b1;
						end else begin
							st_q <= ST_MEAS;
						end
					end
				end
				ST_CAL: begin
					if (win_end) begin
						coef_q      <= CAL_EXPECT - cnt_q;
						coef_ok_q   <= 1'b1;
						tctr_q      <= TEMP_PERIOD;
						meas_next_q <= 1'b0;
						st_q        <= meas_next_q ? ST_MEAS : ST_IDLE;
					end
				end
				ST_MEAS: begin
					if (win_end) begin
						vs_q[fi_q] <= ctrl_q.multi ? fprod[29:12] : corr;
						if (ctrl_q.multi && (fi_q != 2'd2)) begin
							fi_q <= fi_q + 2'd1;
						end else begin
							st_q <= ST_JUDGE;
						end
					end
				end
				ST_JUDGE: st_q <= ST_DONE;
				ST_DONE: begin
					st_q <= ST_IDLE;
					if (tctr_q != 8'h00) begin
						tctr_q <= tctr_q - 8'h01;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign cal_active   = (st_q == ST_CAL);
	assign temp_ref_sel = (st_q == ST_CAL) && meas_next_q;

	// ************************************************
	// Majority judgment
	// ************************************************
	assign vote_ok = ctrl_q.vote_mode && ctrl_q.button_if && (ctrl_q.mtype != MT_CURR);

	tsmj_judge u_judge (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (st_q == ST_JUDGE),
		.multi   (ctrl_q.multi),
		.vote    (vote_ok),
		.v1      (vs_q[0]),
		.v2      (vs_q[1]),
		.v3      (vs_q[2]),
		.thr     (thr_q),
		.value_q (jval),
		.touch_q (jtouch)
	);

	// ************************************************
	// Moving average
	// ************************************************
	assign sum_n = sum_q + {3'b000, jval} - {3'b000, hist_q[3'(wr_q - (3'h1 << tim_q.avg_log[1:0]))]};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_q  <= '{default: 19'h00000};
			wr_q    <= 3'h0;
			sum_q   <= 22'h000000;
			avg_q   <= 19'h00000;
			touch_q <= 1'b0;
		end else if (st_q == ST_DONE) begin
			hist_q[wr_q] <= jval;
			wr_q         <= wr_q + 3'h1;
			sum_q        <= sum_n;
			avg_q        <= 19'(sum_n >> tim_q.avg_log[1:0]);
			touch_q      <= jtouch;
		end
	end

	assign touch = touch_q;

	// ************************************************
	// Offset target and tuning
	// ************************************************
	always_comb begin
		full  = ctrl_q.multi ? MC_FULL : SF_FULL;
		bspan = ctrl_q.multi ? 8'(MC_BASE_SPAN) : 8'(SF_BASE_SPAN);
		span  = ctrl_q.multi ? {4'h0, tim_q.meas_count_setting} + 8'h01
			: 8'(({4'h0, tim_q.meas_count_setting} + 8'h01) * ({4'h0, dpd} + 8'h01));
		case (ctrl_q.mtype)
			MT_MUTUAL: pm = PM_MUTUAL;
			MT_SHIELD: pm = ctrl_q.multi ? PM_SHIELD : PM_SELF;
			default:   pm = PM_SELF;
		endcase
		tprod  = {32'h0, full} * {38'h0, pm} * {40'h0, span};
		target = 24'(tprod / ({38'h0, PM_DEN} * {40'h0, bspan}));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ofs_q <= OFFSET_RST;
		end else if (acc_wr && (a_addr_q == OFS_OFFSET)) begin
			ofs_q <= hwdata[9:0];
		end else if ((st_q == ST_DONE) && ctrl_q.ofs_adj_en) begin
			if (({6'h00, vs_q[0]} > {target} + {8'h00, OFS_TOL}) && (ofs_q != 10'h3FF)) begin
				ofs_q <= ofs_q + 10'h001;
			end else if (({6'h00, vs_q[0]} + {8'h00, OFS_TOL} < target) && (ofs_q != 10'h000)) begin
				ofs_q <= ofs_q - 10'h001;
			end
		end
	end

	assign offset_current = ofs_q;

	// ************************************************
	// Status flags
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= 9'h000;
		end else begin
			if (acc_rd && (haddr[7:0] == OFS_STATUS)) begin
				stat_q <= 9'h000;
			end
			if (st_q == ST_MEAS) begin
				if (!ctrl_q.multi && s2_q[1]) stat_q[1] <= 1'b1;
				if (!ctrl_q.multi && cco_edge && (cnt_q == 16'hFFFF)) stat_q[2] <= 1'b1;
				if (ctrl_q.multi && s2_q[2]) stat_q[3] <= 1'b1;
				if (ctrl_q.multi && s2_q[3]) stat_q[4] <= 1'b1;
				if (ctrl_q.multi && cco_edge && (cnt_q == 16'hFFFF)) stat_q[5] <= 1'b1;
			end
			if (st_q == ST_DONE) begin
				stat_q[0] <= 1'b1;
			end
		end
	end

	assign done = stat_q[0];

endmodule

// ===== test/tsmj_sensor.sv
`timescale 1ns/1ps
module tsmj_sensor (
	input  wire logic       hclk,
	input  wire logic [7:0] half,
	output logic            cco_in
);
	logic [7:0] cnt_q;

	initial begin
		cco_in = 1'b0;
		cnt_q = 8'h00;
	end

	// Oscillator stands still while half is zero
	always @(posedge hclk) begin
		if (half == 8'h00) begin
			cco_in <= 1'b0;
			cnt_q <= 8'h00;
		end else if (cnt_q + 8'h01 >= half) begin
			cco_in <= ~cco_in;
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// ===== test/tsmj_top_sva.sv
`timescale 1ns/1ps
module tsmj_top_sva
	import tsmj_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        drive_pulse,
	input wire logic        shield_pulse,
	input wire logic        cal_active,
	input wire logic        temp_ref_sel,
	input wire logic        done
);
	logic [12:0] cyc_q;
	logic        rd_a;

	assign rd_a = hsel && hready && htrans[1] && !hwrite;

	// Cycles since reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q <= 13'h0000;
		end else if (cyc_q != 13'h1FFF) begin
			cyc_q <= cyc_q + 13'h0001;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_CAL_WIN:
	assert property (cyc_q > 13'h0001 && cyc_q < 13'h1770 |-> cal_active)
		else $error("calibration cut short");
	AST_CAL_END:
	assert property (cyc_q == 13'h19C8 |-> !cal_active)
		else $error("calibration overran");
	AST_SPREAD:
	assert property (rd_a && haddr[7:0] == OFS_SPREAD |=> hrdata == 32'h0000000C)
		else $error("spread readback wrong");
	AST_RDATA_HOLD:
	assert property (!rd_a |=> $stable(hrdata))
		else $error("read data moved");
	AST_DONE_STICKY:
	assert property (done && !(rd_a && haddr[7:0] == OFS_STATUS) |=> done)
		else $error("done dropped unread");
	AST_DONE_REST:
	assert property ($rose(done) |-> !drive_pulse && !shield_pulse)
		else $error("drive active at done");
	AST_SHIELD:
	assert property (shield_pulse |-> drive_pulse && !cal_active)
		else $error("shield out of phase");
	AST_TEMP_REF:
	assert property (temp_ref_sel |-> cal_active)
		else $error("reference select outside calibration");
	AST_BUS_OKAY:
	assert property (hreadyout && !hresp)
		else $error("bus response not okay");
endmodule

bind tsmj_top tsmj_top_sva u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .drive_pulse(drive_pulse),
	.shield_pulse(shield_pulse), .cal_active(cal_active),
	.temp_ref_sel(temp_ref_sel), .done(done)
);

// ===== test/tsmj_top_tb.sv
`timescale 1ns/1ps
module tsmj_top_tb
	import tsmj_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, oc, rc0, rc1;
	logic        drive_pulse, shield_pulse, cal_active, temp_ref_sel, touch, done;
	logic        cco_in;
	logic [31:0] haddr, hwdata, hrdata, d, r1;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [9:0]  offset_current;
	logic [7:0]  half;
	int          n_fail, checked, n_sh, s;
	logic [27:0] tg [9] = '{28'h0033C00, 28'h0232800, 28'h0077800, 28'h0011E00,
		28'h80F2D00, 28'h81F1200, 28'h82F1E00, 28'h8071680, 28'h8030B40};

	tsmj_top u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cco_in(cco_in), .overcurrent_in(oc), .ref_cmp0_in(rc0), .ref_cmp1_in(rc1),
		.drive_pulse(drive_pulse), .shield_pulse(shield_pulse),
		.offset_current(offset_current), .cal_active(cal_active),
		.temp_ref_sel(temp_ref_sel), .touch(touch), .done(done)
	);

	tsmj_sensor u_sense (.hclk(hclk), .half(half), .cco_in(cco_in));

	always #20 hclk = ~hclk;

	always @(posedge hclk) begin
		if (shield_pulse === 1'b1) begin
			n_sh <= n_sh + 1;
		end
	end

	// ****************************
	// Tasks
	// ****************************
	task close_out;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic wait_for(ref logic sig, input logic v);
		int k;
		k = 0;
		while (sig !== v && k < 9000) begin
			@(negedge hclk);
			k++;
		end
		@(posedge hclk);
		if (k >= 9000) begin
			n_fail++;
			$display("[FAIL] %0t wait timed out", $time);
			close_out;
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		d = hrdata;
		if (k >= 64) begin
			n_fail++;
			$display("[FAIL] %0t bus timed out", $time);
			close_out;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(d, e);
	endtask

	task automatic scan(input logic [7:0] c);
		bus(1'b1, OFS_CTRL, {23'h0, 1'b1, c});
		wait_for(done, 1'b1);
		bus(1'b0, OFS_STATUS, 32'h0);
	endtask

	// ****************************
	// Sequence
	// ****************************
	initial begin
		{hclk, hresetn, hsel, hwrite, oc, rc0, rc1} = 7'h00;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		half = 8'h02;
		{n_fail, checked, n_sh} = 96'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(OFS_CTRL, 32'(CTRL_RST));
		rdc(OFS_TIMING, TIMING_RST);
		rdc(OFS_DPDIV, 32'(DPDIV_RST));
		rdc(OFS_THRESH, 32'(THRESH_RST));
		rdc(OFS_SPREAD, 32'h0000000C);
		rdc(8'h3C, 32'h0);
		wait_for(cal_active, 1'b0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(d[11:10], 2'h2);
		$display("reset test done");
		foreach (tg[i]) begin
			bus(1'b1, OFS_CTRL, {24'h0, tg[i][27:20]});
			bus(1'b1, OFS_TIMING, {28'h03210F0, tg[i][19:16]});
			rdc(OFS_TARGET, {16'h0, tg[i][15:0]});
		end
		$display("target test done");
		bus(1'b1, OFS_TIMING, 32'h13210F00);
		bus(1'b1, OFS_DPDIV, 32'h0);
		bus(1'b1, OFS_THRESH, 32'h0);
		bus(1'b1, OFS_OFFSET, 32'h155);
		oc <= 1'b1;
		scan(8'h00);
		oc <= 1'b0;
		chk(d[1:0], 2'h3);
		chk(touch, 1'b1);
		chk(offset_current, 10'h155);
		rdc(OFS_STATUS, 32'h0000_0A00);
		bus(1'b0, OFS_RESULT, 32'h0);
		r1 = d;
		scan(8'h00);
		bus(1'b0, OFS_RESULT, 32'h0);
		chk({31'h0, r1 + r1 + 32'h2 - d <= 32'h4}, 32'h1);
		$display("single scan test done");
		bus(1'b1, OFS_THRESH, 32'h0800);
		{rc0, rc1} <= 2'h3;
		s = n_sh;
		scan(8'hC4);
		{rc0, rc1} <= 2'h0;
		chk(d[4:3], 2'h3);
		chk(touch, 1'b1);
		chk(n_sh - s, 0);
		scan(8'h91);
		chk(touch, 1'b0);
		chk(n_sh > s, 1);
		$display("multi scan test done");
		bus(1'b1, OFS_OFFSET, 32'h155);
		scan(8'h20);
		chk(offset_current, 10'h156);
		$display("offset test done");
		repeat (59) scan(8'h00);
		bus(1'b1, OFS_CTRL, 32'h0000_0188);
		wait_for(temp_ref_sel, 1'b1);
		wait_for(done, 1'b1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({d[11:10], d[0]}, 3'h5);
		$display("temp test done");
		close_out;
	end
endmodule
